// ==== include/tza_defines.svh ====
// Register offsets, field positions, reset values and status bits of the trip block
`ifndef PTZ_DEFINES_SVH
`define PTZ_DEFINES_SVH

`define PTZ_OFF_SELECT      8'h00
`define PTZ_OFF_ACTION      8'h04
`define PTZ_OFF_STATUS      8'h08
`define PTZ_OFF_MASK        8'h0c
`define PTZ_OFF_CLEAR       8'h10
`define PTZ_OFF_PINS        8'h14

`define PTZ_SEL_CYC_LSB     0
`define PTZ_SEL_OST_LSB     8
`define PTZ_SEL_WMASK       16'h3f3f
`define PTZ_ACT_A_LSB       0
`define PTZ_ACT_B_LSB       2
`define PTZ_ACT_WMASK       16'h000f

`define PTZ_SEL_RESET       16'h0000
`define PTZ_ACT_RESET       16'h0000
`define PTZ_MASK_RESET      3'h0

`define PTZ_ST_ANY          0
`define PTZ_ST_CYC          1
`define PTZ_ST_OST          2

`define PTZ_RESP_OKAY       2'h0
`define PTZ_RESP_SLVERR     2'h2

`endif

// ==== include/tza_pkg.sv ====
// Types shared by the trip block files
package ptz_pkg;

    // Per-output trip action codes
    typedef enum logic [1:0] {
        PTZ_ACT_HIZ  = 2'h0,
        PTZ_ACT_HIGH = 2'h1,
        PTZ_ACT_LOW  = 2'h2,
        PTZ_ACT_NONE = 2'h3
    } ptz_action_t;

    // One PWM pin as value plus output enable
    typedef struct packed {
        logic val;
        logic oe;
    } ptz_pin_t;

    // AXI4-Lite request side
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } ptz_axi_req_t;

    // AXI4-Lite response side
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ptz_axi_rsp_t;

    // Write-response state machine
    typedef enum logic [2:0] {
        PTZ_W_IDLE = 3'b001,
        PTZ_W_HALF = 3'b010,
        PTZ_W_RESP = 3'b100
    } ptz_wstate_t;

endpackage

// ==== logic/tza_pin_force.sv ====
// One PWM output with its trip action override
`timescale 1ns/1ps
module ptz_pin_force (
    input  wire logic                 tripped,
    input  wire ptz_pkg::ptz_action_t action,
    input  wire logic                 pwm_in,
    output ptz_pkg::ptz_pin_t         pin
);
    import ptz_pkg::*;

    // Force only while tripped; code "none" passes the PWM through
    always_comb begin
        pin = '{val: pwm_in, oe: 1'b1};
        if (tripped) begin
            case (action)
                PTZ_ACT_HIZ:  pin = '{val: 1'b0, oe: 1'b0};
                PTZ_ACT_HIGH: pin = '{val: 1'b1, oe: 1'b1};
                PTZ_ACT_LOW:  pin = '{val: 1'b0, oe: 1'b1};
                default:      pin = '{val: pwm_in, oe: 1'b1};
            endcase
        end
    end
endmodule

// ==== logic/tza_trip_zone.sv ====
// Trip-zone source select, trip latches, output override and AXI4-Lite registers
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tza_defines.svh"
module ptz_trip_zone (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire ptz_pkg::ptz_axi_req_t axi_req,
    output ptz_pkg::ptz_axi_rsp_t  axi_rsp,
    input  wire logic [5:0]        fault_input_n,
    input  wire logic              tb_counter_zero,
    input  wire logic              pwm_in_a,
    input  wire logic              pwm_in_b,
    output logic                   pwm_out_a,
    output logic                   pwm_out_a_oe,
    output logic                   pwm_out_b,
    output logic                   pwm_out_b_oe,
    output logic                   trip_irq
);
    import ptz_pkg::*;

    // Software-visible state
    logic [15:0] trip_source_select_q;  // Source enables
    logic [15:0] trip_output_action_q;  // Pin actions
    logic [2:0]  status_q;              // Sticky event flags
    logic [2:0]  mask_q;                // Interrupt mask
    logic        oneshot_q;             // Latched one-shot trip
    logic        cyclewise_q;           // Cycle-by-cycle trip condition
    logic        cyclewise_trip_status; // Alias of status bit

    // Bus channel state
    ptz_wstate_t wstate_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // Source decode
    wire [5:0] cyc_en   = trip_source_select_q[`PTZ_SEL_CYC_LSB +: 6];
    wire [5:0] ost_en   = trip_source_select_q[`PTZ_SEL_OST_LSB +: 6];
    wire [5:0] fault_lo = ~fault_input_n;
    wire       cyc_hit  = |(cyc_en & fault_lo);
    wire       ost_hit  = |(ost_en & fault_lo);

    // Action decode
    wire ptz_action_t act_a = ptz_action_t'(trip_output_action_q[`PTZ_ACT_A_LSB +: 2]);
    wire ptz_action_t act_b = ptz_action_t'(trip_output_action_q[`PTZ_ACT_B_LSB +: 2]);

    // Trip is the OR of both causes; release needs both gone
    wire tripped = oneshot_q | cyclewise_q | ost_hit | cyc_hit;

    // Write path decode
    wire aw_take   = axi_req.awvalid & ~aw_have_q & ~bvalid_q;
    wire w_take    = axi_req.wvalid & ~w_have_q & ~bvalid_q;
    wire aw_ok     = aw_have_q | aw_take;
    wire w_ok      = w_have_q | w_take;
    wire wr_fire   = aw_ok & w_ok & ~bvalid_q;
    wire [7:0]  wr_addr = aw_have_q ? awaddr_q : axi_req.awaddr;
    wire [31:0] wr_data = w_have_q ? wdata_q : axi_req.wdata;
    wire [3:0]  wr_strb = w_have_q ? wstrb_q : axi_req.wstrb;
    wire [15:0] wr_bmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_sel  = wr_fire & (wr_addr == `PTZ_OFF_SELECT);
    wire wr_act  = wr_fire & (wr_addr == `PTZ_OFF_ACTION);
    wire wr_stat = wr_fire & (wr_addr == `PTZ_OFF_STATUS);
    wire wr_mask = wr_fire & (wr_addr == `PTZ_OFF_MASK);
    wire wr_clr  = wr_fire & (wr_addr == `PTZ_OFF_CLEAR);
    wire wr_pins = wr_fire & (wr_addr == `PTZ_OFF_PINS);
    wire wr_known = wr_sel | wr_act | wr_stat | wr_mask | wr_clr | wr_pins;

    // Clear strobes, write-one-to-clear
    wire [2:0] st_clr   = wr_stat ? (wr_data[2:0] & {3{wr_strb[0]}}) : 3'h0;
    wire [2:0] trip_clr = wr_clr  ? (wr_data[2:0] & {3{wr_strb[0]}}) : 3'h0;

    // Read path decode
    wire rd_take = axi_req.arvalid & ~rvalid_q;
    logic [31:0] rd_word;
    logic        rd_known;

    // Status read view
    assign cyclewise_trip_status = status_q[`PTZ_ST_CYC];

    // Read mux
    always_comb begin
        rd_word  = 32'h0;
        rd_known = 1'b1;
        case (axi_req.araddr)
            `PTZ_OFF_SELECT: rd_word = {16'h0, trip_source_select_q};
            `PTZ_OFF_ACTION: rd_word = {16'h0, trip_output_action_q};
            `PTZ_OFF_STATUS: rd_word = {29'h0, status_q[`PTZ_ST_OST], cyclewise_trip_status,
                                        status_q[`PTZ_ST_ANY]};
            `PTZ_OFF_MASK:   rd_word = {29'h0, mask_q};
            `PTZ_OFF_CLEAR:  rd_word = 32'h0;
            `PTZ_OFF_PINS:   rd_word = {24'h0, 1'b0, tripped, oneshot_q,
                                        cyclewise_q, 4'h0} | {26'h0, fault_lo};
            default:         rd_known = 1'b0;
        endcase
    end

    // Configuration registers, reserved bits held zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trip_source_select_q <= `PTZ_SEL_RESET;
            trip_output_action_q <= `PTZ_ACT_RESET;
            mask_q               <= `PTZ_MASK_RESET;
        end else begin
            if (wr_sel) begin
                trip_source_select_q <= (trip_source_select_q & ~(wr_bmask & `PTZ_SEL_WMASK))
                                      | (wr_data[15:0] & wr_bmask & `PTZ_SEL_WMASK);
            end
            if (wr_act) begin
                trip_output_action_q <= (trip_output_action_q & ~(wr_bmask & `PTZ_ACT_WMASK))
                                      | (wr_data[15:0] & wr_bmask & `PTZ_ACT_WMASK);
            end
            if (wr_mask && wr_strb[0]) begin
                mask_q <= wr_data[2:0];
            end
        end
    end

    // One-shot latch: set by a hit, held until cleared; set wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oneshot_q <= 1'b0;
        end else if (ost_hit) begin
            oneshot_q <= 1'b1;
        end else if (trip_clr[`PTZ_ST_OST]) begin
            oneshot_q <= 1'b0;
        end
    end

    // Cycle condition: held until counter zero with input released
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cyclewise_q <= 1'b0;
        end else if (cyc_hit) begin
            cyclewise_q <= 1'b1;
        end else if (tb_counter_zero) begin
            cyclewise_q <= 1'b0;
        end
    end

    // Sticky event flags; a live source re-sets on clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 3'h0;
        end else begin
            status_q[`PTZ_ST_CYC] <= cyc_hit | (status_q[`PTZ_ST_CYC]
                                     & ~st_clr[`PTZ_ST_CYC] & ~trip_clr[`PTZ_ST_CYC]);
            status_q[`PTZ_ST_OST] <= ost_hit | (status_q[`PTZ_ST_OST]
                                     & ~st_clr[`PTZ_ST_OST] & ~trip_clr[`PTZ_ST_OST]);
            status_q[`PTZ_ST_ANY] <= ost_hit | cyc_hit | (status_q[`PTZ_ST_ANY]
                                     & ~st_clr[`PTZ_ST_ANY] & ~trip_clr[`PTZ_ST_ANY]);
        end
    end

    // Interrupt level from unmasked flags
    assign trip_irq = |(status_q & mask_q);

    // Write state sequencing, records which half arrived
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wstate_q  <= PTZ_W_IDLE;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
        end else begin
            case (wstate_q)
                PTZ_W_IDLE, PTZ_W_HALF: begin
                    if (wr_fire) begin
                        aw_have_q <= 1'b0;
                        w_have_q  <= 1'b0;
                        wstate_q  <= PTZ_W_RESP;
                    end else if (aw_take || w_take) begin
                        wstate_q <= PTZ_W_HALF;
                        if (aw_take) begin
                            aw_have_q <= 1'b1;
                            awaddr_q  <= axi_req.awaddr;
                        end
                        if (w_take) begin
                            w_have_q <= 1'b1;
                            wdata_q  <= axi_req.wdata;
                            wstrb_q  <= axi_req.wstrb;
                        end
                    end
                end
                PTZ_W_RESP: begin
                    if (axi_req.bready) begin
                        wstate_q <= PTZ_W_IDLE;
                    end
                end
                default: wstate_q <= PTZ_W_IDLE;
            endcase
        end
    end

    // Write response register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `PTZ_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? `PTZ_RESP_OKAY : `PTZ_RESP_SLVERR;
        end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read response register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `PTZ_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_known ? `PTZ_RESP_OKAY : `PTZ_RESP_SLVERR;
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Bus outputs; readies are combinational handshakes
    assign axi_rsp.awready = aw_take;
    assign axi_rsp.wready  = w_take;
    assign axi_rsp.bvalid  = bvalid_q;
    assign axi_rsp.bresp   = bresp_q;
    assign axi_rsp.arready = rd_take;
    assign axi_rsp.rvalid  = rvalid_q;
    assign axi_rsp.rdata   = rdata_q;
    assign axi_rsp.rresp   = rresp_q;

    // Output overrides share one trip state
    ptz_pin_t pin_a;
    ptz_pin_t pin_b;

    ptz_pin_force u_force_a (
        .tripped (tripped),
        .action  (act_a),
        .pwm_in  (pwm_in_a),
        .pin     (pin_a)
    );

    ptz_pin_force u_force_b (
        .tripped (tripped),
        .action  (act_b),
        .pwm_in  (pwm_in_b),
        .pin     (pin_b)
    );

    // Pin outputs; combinational so a fault overrides within the cycle
    assign pwm_out_a    = pin_a.val;
    assign pwm_out_a_oe = pin_a.oe;
    assign pwm_out_b    = pin_b.val;
    assign pwm_out_b_oe = pin_b.oe;
endmodule

// ==== sim/tza_trip_checker.sv ====
// Checks of trip forcing, latch hold and bus answers
`timescale 1ns/1ps
`include "tza_defines.svh"
module ptz_trip_checker (
    input wire logic                  clk_sys,
    input wire logic                  reset_n,
    input wire ptz_pkg::ptz_axi_req_t axi_req,
    input wire ptz_pkg::ptz_axi_rsp_t axi_rsp,
    input wire logic [5:0]            fault_input_n,
    input wire logic                  tb_counter_zero,
    input wire logic                  pwm_in_a,
    input wire logic                  pwm_in_b,
    input wire logic                  pwm_out_a,
    input wire logic                  pwm_out_a_oe,
    input wire logic                  pwm_out_b,
    input wire logic                  pwm_out_b_oe,
    input wire logic                  trip_irq
);
    import ptz_pkg::*;
    logic [15:0] sel_q;   // Select shadow
    logic [3:0]  act_q;   // Action shadow
    logic        mask1_q; // Cycle mask shadow
    logic        ost_q;   // Expected one-shot latch
    logic        cyc_q;   // Expected cycle latch
    // Shadow only sees writes whose halves meet in one edge
    wire       wr_go   = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    wire [7:0] wa      = axi_req.awaddr;
    wire [5:0] low_w   = ~fault_input_n;
    wire       cyc_now = |(low_w & sel_q[5:0]);
    wire       ost_now = |(low_w & sel_q[13:8]);
    // One pin against its action code
    function automatic logic pin_ok(logic [1:0] c, logic i, logic v, logic oe);
        return c == 2'h0 ? !oe : c == 2'h3 ? (oe && v == i) : (oe && v == (c == 2'h1));
    endfunction
    wire forced_ok = pin_ok(act_q[1:0], pwm_in_a, pwm_out_a, pwm_out_a_oe)
                  && pin_ok(act_q[3:2], pwm_in_b, pwm_out_b, pwm_out_b_oe);
    wire pass_ok   = pin_ok(2'h3, pwm_in_a, pwm_out_a, pwm_out_a_oe)
                  && pin_ok(2'h3, pwm_in_b, pwm_out_b, pwm_out_b_oe);
    // Mirror registers and latches; set beats clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sel_q   <= '0;
            act_q   <= '0;
            mask1_q <= 1'b0;
            ost_q   <= 1'b0;
            cyc_q   <= 1'b0;
        end else begin
            if (wr_go && wa == `PTZ_OFF_SELECT) sel_q <= axi_req.wdata[15:0] & `PTZ_SEL_WMASK;
            if (wr_go && wa == `PTZ_OFF_ACTION) act_q <= axi_req.wdata[3:0];
            if (wr_go && wa == `PTZ_OFF_MASK) mask1_q <= axi_req.wdata[1];
            ost_q <= ost_now || (ost_q && !(wr_go && wa == `PTZ_OFF_CLEAR && axi_req.wdata[2]));
            cyc_q <= cyc_now || (cyc_q && !tb_counter_zero);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    trip_force_a: assert property (cyc_now || ost_now |-> forced_ok)
        else $error("pins not forced by trip");
    ost_hold_a: assert property (ost_q |-> forced_ok)
        else $error("one-shot trip released early");
    cyc_hold_a: assert property (cyc_q |-> forced_ok)
        else $error("cycle trip released before zero");
    trip_release_a: assert property (!ost_q && !cyc_q && !cyc_now && !ost_now |-> pass_ok)
        else $error("pins held after both trips ended");
    cyc_reset_a: assert property (cyc_now && mask1_q |=> trip_irq)
        else $error("cycle status not set again");
    wr_answer_a: assert property (wr_go |=> axi_rsp.bvalid)
        else $error("no write response");
    b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
        else $error("write response dropped");
    rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("no read response");
    r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> $stable(axi_rsp.rdata))
        else $error("read data changed while held");
    cover property (ost_q && !ost_now && wr_go);
    cover property (cyc_q && tb_counter_zero);
    cover property ($rose(trip_irq));
endmodule
bind ptz_trip_zone ptz_trip_checker i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .fault_input_n(fault_input_n),
    .tb_counter_zero(tb_counter_zero), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b),
    .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b),
    .pwm_out_b_oe(pwm_out_b_oe), .trip_irq(trip_irq));

// ==== sim/tza_fault_src.sv ====
// Model of the external fault sources
`timescale 1ns/1ps
module ptz_fault_src (
    input  wire logic [5:0] trip_req,     // Sources now in fault
    output logic      [5:0] fault_input_n // Active-low lines, pulled up when idle
);
    assign fault_input_n = ~trip_req;
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench of the trip block
`timescale 1ns/1ps
`include "tza_defines.svh"
module tb_top;
    import ptz_pkg::*;
    logic         clk_sys, reset_n, zero, in_a, in_b, out_a, oe_a, out_b, oe_b, irq;
    logic [5:0]   trip_req;        // Faulted sources
    logic [5:0]   fault_n;         // Lines to the block
    ptz_axi_req_t req;             // Bus request
    ptz_axi_rsp_t rsp;             // Bus answer
    logic [31:0]  rd_v;            // Last read data
    logic [1:0]   resp;            // Last response code
    int           mismatches;
    int           samples_checked;
    ptz_fault_src i_src (.trip_req(trip_req), .fault_input_n(fault_n));
    ptz_trip_zone i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp),
        .fault_input_n(fault_n), .tb_counter_zero(zero), .pwm_in_a(in_a), .pwm_in_b(in_b),
        .pwm_out_a(out_a), .pwm_out_a_oe(oe_a), .pwm_out_b(out_b), .pwm_out_b_oe(oe_b),
        .trip_irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write; bready rises late so a held response is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (n == 2) req.bready <= 1'b1;
        end while (!(rsp.bvalid && req.bready));
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (n == 2) req.rready <= 1'b1;
        end while (!(rsp.rvalid && req.rready));
        rd_v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic logic [1:0] pin_exp(input logic [1:0] c, input logic i);
        case (c)
            2'h0: return 2'b00;
            2'h1: return 2'b11;
            2'h2: return 2'b10;
            default: return {1'b1, i};
        endcase
    endfunction
    // Pin value counts only while driven
    task automatic pins(input logic [1:0] ca, input logic [1:0] cb);
        chk({28'h0, oe_a, out_a & oe_a, oe_b, out_b & oe_b},
            {28'h0, pin_exp(ca, in_a), pin_exp(cb, in_b)});
    endtask
    task automatic zero_pulse;
        zero <= 1'b1;
        @(posedge clk_sys);
        zero <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Whole run needs about 250 cycles
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    initial begin
        {req, zero, trip_req, reset_n, mismatches, samples_checked} = '0;
        in_a = 1'b1;
        in_b = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(`PTZ_OFF_SELECT);
        chk(rd_v, 32'h0);
        wr(`PTZ_OFF_SELECT, 32'hffff_ffff);
        chk({30'h0, resp}, 32'h0);
        rd(`PTZ_OFF_SELECT);
        chk(rd_v, 32'h3f3f);
        wr(`PTZ_OFF_ACTION, 32'hffff_ffff);
        rd(`PTZ_OFF_ACTION);
        chk(rd_v, 32'hf);
        rd(8'h1c);
        chk({30'h0, resp}, 32'h2);
        wr(8'h1c, 32'h0);
        chk({30'h0, resp}, 32'h2);
        // Cycle trip per input, every action code on both pins
        for (int k = 0; k < 6; k++) begin
            wr(`PTZ_OFF_SELECT, 32'h1 << k);
            wr(`PTZ_OFF_ACTION, {28'h0, k[1:0], ~k[1:0]});
            trip_req <= 6'h1 << k;
            @(posedge clk_sys);
            pins(~k[1:0], k[1:0]);
            trip_req <= 6'h0;
            repeat (2) @(posedge clk_sys);
            pins(~k[1:0], k[1:0]);
            zero_pulse();
            pins(2'h3, 2'h3);
        end
        // One-shot per input survives zero until cleared
        wr(`PTZ_OFF_ACTION, 32'ha);
        for (int k = 0; k < 6; k++) begin
            wr(`PTZ_OFF_SELECT, 32'h100 << k);
            trip_req <= 6'h1 << k;
            @(posedge clk_sys);
            trip_req <= 6'h0;
            zero_pulse();
            pins(2'h2, 2'h2);
            wr(`PTZ_OFF_CLEAR, 32'h4);
            pins(2'h3, 2'h3);
            trip_req <= ~(6'h1 << k);
            @(posedge clk_sys);
            pins(2'h3, 2'h3);
            trip_req <= 6'h0;
        end
        // Status cleared while the input is still low
        wr(`PTZ_OFF_STATUS, 32'h7);
        wr(`PTZ_OFF_MASK, 32'h2);
        wr(`PTZ_OFF_SELECT, 32'h1);
        trip_req <= 6'h1;
        wr(`PTZ_OFF_STATUS, 32'h2);
        rd(`PTZ_OFF_STATUS);
        chk(rd_v & 32'h2, 32'h2);
        chk({31'h0, irq}, 32'h1);
        // Live view: tripped bit6, cycle latch bit4, input 0 low bit0
        rd(`PTZ_OFF_PINS);
        chk(rd_v, 32'h51);
        trip_req <= 6'h0;
        zero_pulse();
        wr(`PTZ_OFF_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`PTZ_OFF_STATUS, 32'h7);
        wr(`PTZ_OFF_MASK, 32'h2);
        chk({31'h0, irq}, 32'h0);
        // Both trips at once: leave only when both end
        wr(`PTZ_OFF_SELECT, 32'h0201);
        trip_req <= 6'h3;
        @(posedge clk_sys);
        trip_req <= 6'h0;
        wr(`PTZ_OFF_CLEAR, 32'h4);
        pins(2'h2, 2'h2);
        zero_pulse();
        pins(2'h3, 2'h3);
        // Other order: counter zero first, one-shot still holds
        trip_req <= 6'h3;
        @(posedge clk_sys);
        trip_req <= 6'h0;
        zero_pulse();
        pins(2'h2, 2'h2);
        wr(`PTZ_OFF_CLEAR, 32'h4);
        pins(2'h3, 2'h3);
        summarize();
    end
endmodule
